// ==== src/pss_pkg.sv ====
// Shared constants and types for the power stage sync and output control block
package pss_pkg;

   // ------------------------------------------------------------
   // Structure
   // ------------------------------------------------------------
   localparam int           NUM_UNITS   = 3;
   localparam int           UNIT_THIRD  = 2;          // Unit with four outputs
   localparam int           DATA_W      = 32;
   localparam int           REG_W       = 8;

   // ------------------------------------------------------------
   // Register map: byte offset = unit * stride + register offset
   // ------------------------------------------------------------
   localparam int           UNIT_LSB    = 4;
   localparam logic [3:0]   OFS_CTRL    = 4'h0;       // unit_control_register
   localparam logic [3:0]   OFS_CONF    = 4'h4;       // unit_configuration_register
   localparam logic [3:0]   OFS_SOC     = 4'h8;       // sync_output_config_unitN
   localparam logic [3:0]   OFS_EVT     = 4'hC;       // Event enables and status
   localparam logic [7:0]   REG_RESET   = 8'h00;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int           CTRL_RUN    = 0;          // run_bit
   localparam int           CTRL_AUTO   = 2;          // autorun_bit
   localparam int           CTRL_PRE    = 6;          // prescale_field, 2 bits
   localparam int           CONF_CLKSEL = 1;          // clock_source_select
   localparam int           CONF_MODE   = 3;          // Running mode, 2 bits
   localparam int           SOC_A_EN    = 0;          // output_a_enable
   localparam int           SOC_C_EN    = 1;          // third_output_enable
   localparam int           SOC_B_EN    = 2;          // output_b_enable
   localparam int           SOC_D_EN    = 3;          // fourth_output_enable
   localparam int           SOC_SYNC    = 4;          // adc_strobe_select, 2 bits
   localparam int           SOC_S22     = 6;          // third_output_source_select
   localparam int           SOC_S23     = 7;          // fourth_output_source_select
   localparam int           EVT_EN_EC   = 0;
   localparam int           EVT_EN_CAPTURE_IRQ = 1;
   localparam int           EVT_F7_EN   = 2;
   localparam int           EVT_IN_POL  = 3;
   localparam int           EVT_ST_RUN  = 4;
   localparam int           EVT_ST_HALT = 5;
   localparam logic [3:0]   EVT_WMASK   = 4'hF;

   // ------------------------------------------------------------
   // Encodings
   // ------------------------------------------------------------
   localparam logic [1:0]   MODE_CENTRED = 2'h3;
   localparam logic [1:0]   SYNC_A_LEAD  = 2'h0;
   localparam logic [1:0]   SYNC_A_TRAIL = 2'h1;
   localparam logic [1:0]   SYNC_B_LEAD  = 2'h2;
   localparam logic [1:0]   SYNC_B_TRAIL = 2'h3;
   localparam logic [1:0]   PRE_DIV1     = 2'h0;
   localparam logic [1:0]   PRE_DIV4     = 2'h1;
   localparam logic [1:0]   PRE_DIV32    = 2'h2;
   localparam logic [7:0]   MASK_DIV1    = 8'h00;
   localparam logic [7:0]   MASK_DIV4    = 8'h03;
   localparam logic [7:0]   MASK_DIV32   = 8'h1F;
   localparam logic [7:0]   MASK_DIV256  = 8'hFF;

   // ------------------------------------------------------------
   // Interrupt program addresses
   // ------------------------------------------------------------
   localparam logic [15:0]  VEC_U2_CAPTURE_IRQ  = 16'h0001;
   localparam logic [15:0]  VEC_U2_EC    = 16'h0002;
   localparam logic [15:0]  VEC_U0_CAPTURE_IRQ  = 16'h0005;
   localparam logic [15:0]  VEC_U0_EC    = 16'h0006;
   localparam logic [15:0]  VEC_NONE     = 16'h0000;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef struct packed {
      logic gen_a;        // Waveform generator A level
      logic gen_b;        // Waveform generator B level
      logic match_sa;     // Counter equals set_a_compare
      logic match_ra;     // Counter equals reset_a_compare
      logic match_sb;     // Counter equals set_b_compare
      logic match_rb;     // Counter equals reset_b_compare (reload)
      logic fault_a;      // Fault or retrigger end on part A
      logic fault_b;      // Fault or retrigger end on part B
      logic count_down;   // Counter direction in centred mode
      logic ext_in;       // Raw input level
      logic retrig;       // Retrigger event
      logic capture;      // Counter captured
      logic fault7;       // Halt-and-wait fault detected
   } pss_engine_t;

   typedef struct packed {
      logic a;
      logic a_oe;
      logic b;
      logic b_oe;
   } pss_pins_t;

endpackage : pss_pkg

// ==== src/pss_top.sv ====
// Power stage run chaining, fault chaining, clocking, ADC strobe and pin routing
//
// Contract
// - Each unit: reload, input event, sync error
// - Input event on active edge or level start
// - End-of-cycle request on reset-B match
// - Capture request: input event, retrigger, capture or sync error
// - Unit 2 vectors at 0x0001 and 0x0002
// - Unit 0 vectors at 0x0005 and 0x0006
// - Chained units share start, hence aligned waveforms
// - Autorun unit starts with its predecessor
// - Master run bit starts every chained slave
// - Halt fault travels forward and backward
// - Dropping the run signal stops the next unit
// - Only halt faults travel along the chain
// - Slave sends enabled halt fault to predecessor
// - Clock select: 0 I/O clock, 1 PLL
// - Prescale divides by 1, 4, 32, 256
// - Fourth output: B when clear, A when set
// - Third output: A when clear, B when set
// - Ramp modes pick strobe edge of outputs
// - Centred mode strobes on reset-A match direction
// - Output enables hand pins to generators
// - Unit 2 extra enables drive second pins
// - Own run bit overrides autorun bit
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ps

module pss_top #(
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input  wire logic                                pclk,
   input  wire logic                                presetn,
   // APB slave
   input  wire logic                                psel,
   input  wire logic                                penable,
   input  wire logic                                pwrite,
   input  wire logic [ADDR_W-1:0]                   paddr,
   input  wire logic [pss_pkg::DATA_W-1:0]          pwdata,
   input  wire logic [3:0]                          pstrb,
   output logic      [pss_pkg::DATA_W-1:0]          prdata,
   output logic                                     pready,
   output logic                                     pslverr,
   // Clock source ticks, one pclk cycle each
   input  wire logic                                io_tick,
   input  wire logic                                pll_tick,
   // Waveform engine status per unit
   input  wire pss_pkg::pss_engine_t [pss_pkg::NUM_UNITS-1:0] engine,
   // Per-unit results
   output logic      [pss_pkg::NUM_UNITS-1:0]       count_tick,
   output logic      [pss_pkg::NUM_UNITS-1:0]       unit_running,
   output logic      [pss_pkg::NUM_UNITS-1:0]       adc_strobe,
   output logic      [pss_pkg::NUM_UNITS-1:0]       end_of_cycle_irq,
   output logic      [pss_pkg::NUM_UNITS-1:0]       capture_irq,
   output pss_pkg::pss_pins_t [pss_pkg::NUM_UNITS-1:0] pins,
   // Unit 2 second pins
   output logic                                     unit2_third_output,
   output logic                                     unit2_third_oe,
   output logic                                     unit2_fourth_output,
   output logic                                     unit2_fourth_oe,
   // Interrupt vector request
   output logic                                     vec_valid,
   output logic      [15:0]                         vec_addr
);
   import pss_pkg::*;

   localparam int NU = NUM_UNITS;

   // ------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------
   // Prescale field to counter mask
   function automatic logic [7:0] pre_mask(input logic [1:0] sel);
      logic [7:0] m;
      m = MASK_DIV256;
      unique case (sel)
         PRE_DIV1:  m = MASK_DIV1;
         PRE_DIV4:  m = MASK_DIV4;
         PRE_DIV32: m = MASK_DIV32;
         default:   m = MASK_DIV256;
      endcase
      return m;
   endfunction : pre_mask

   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   logic [REG_W-1:0] ctrl_r   [NU];
   logic [REG_W-1:0] conf_r   [NU];
   logic [REG_W-1:0] soc_r    [NU];
   logic [3:0]       evt_r    [NU];
   logic [7:0]       pre_cnt_r[NU];
   logic [NU-1:0]    halt_r;
   logic [NU-1:0]    in_q_r;
   logic [NU-1:0]    mis_q_r;
   logic [NU-1:0]    run_eff;
   logic [NU-1:0]    slave;
   logic [NU-1:0]    f7_local;
   logic [NU-1:0]    f7_hit;
   logic [NU-1:0]    run_now;
   logic [NU-1:0]    ec_req;
   logic [NU-1:0]    capture_irq_req;
   logic [NU-1:0]    wr_ctrl;
   logic [NU-1:0]    run_wr;
   logic             pready_r;

   // ------------------------------------------------------------
   // APB decode
   // ------------------------------------------------------------
   logic                  access;
   logic                  addr_hit;
   logic [1:0]            acc_unit;
   logic [3:0]            acc_ofs;
   logic                  wr_go;
   logic [DATA_W-1:0]     rd_word;

   // Unit index from the upper nibble, anything beyond is unmapped
   assign acc_unit = paddr[UNIT_LSB+1:UNIT_LSB];
   assign acc_ofs  = paddr[UNIT_LSB-1:0];
   assign access   = psel & penable;
   assign addr_hit = (paddr[ADDR_W-1:UNIT_LSB+2] == '0) && (int'(acc_unit) < NU);
   assign wr_go    = access & pready_r & pwrite & addr_hit & pstrb[0];

   // Read mux; reserved upper bits read as zero
   always_comb begin
      rd_word = '0;
      if (addr_hit) begin
         unique case (acc_ofs)
            OFS_CTRL: rd_word[REG_W-1:0] = ctrl_r[acc_unit];
            OFS_CONF: rd_word[REG_W-1:0] = conf_r[acc_unit];
            OFS_SOC:  rd_word[REG_W-1:0] = soc_r[acc_unit];
            OFS_EVT: begin
               rd_word[3:0]         = evt_r[acc_unit];
               rd_word[EVT_ST_RUN]  = unit_running[acc_unit];
               rd_word[EVT_ST_HALT] = halt_r[acc_unit];
            end
            default:  rd_word = '0;
         endcase
      end
   end

   // Two-cycle access: pready rises one edge into the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         prdata   <= '0;
         pslverr  <= 1'b0;
      end else if (access && !pready_r) begin
         pready_r <= 1'b1;
         prdata   <= rd_word;
         pslverr  <= !addr_hit || (acc_ofs[1:0] != 2'h0);
      end else begin
         pready_r <= 1'b0;
         pslverr  <= 1'b0;
      end
   end
   assign pready = pready_r;

   // ------------------------------------------------------------
   // Run chain
   // ------------------------------------------------------------
   // Predecessor of unit n is n-1, unit 0 follows unit 2. Unrolled
   // two hops deep so a closed autorun ring cannot form a loop.
   generate
      for (genvar i = 0; i < NU; i++) begin : g_chain
         localparam int P  = (i + NU - 1) % NU;
         localparam int PP = (i + NU - 2) % NU;
         localparam int N  = (i + 1) % NU;
         assign run_eff[i] = ctrl_r[i][CTRL_RUN]
                           | (ctrl_r[i][CTRL_AUTO]
                              & (ctrl_r[P][CTRL_RUN]
                                 | (ctrl_r[P][CTRL_AUTO] & ctrl_r[PP][CTRL_RUN])));
         assign slave[i]    = ctrl_r[i][CTRL_AUTO] & ~ctrl_r[i][CTRL_RUN];
         // Halt fault counts only when enabled
         assign f7_local[i] = engine[i].fault7 & evt_r[i][EVT_F7_EN];
         // Own fault, forward from predecessor, backward from slave successor
         assign f7_hit[i]   = f7_local[i]
                            | (slave[i] & f7_local[P])
                            | (slave[N] & f7_local[N]);
         assign run_now[i]  = run_eff[i] & ~halt_r[i];
         assign wr_ctrl[i]  = wr_go && (int'(acc_unit) == i) && (acc_ofs == OFS_CTRL);
         assign run_wr[i]   = wr_ctrl[i] & pwdata[CTRL_RUN];
      end
   endgenerate

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   // Control: a halt fault clears the run bit and wins over a write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NU; i++) ctrl_r[i] <= REG_RESET;
      end else begin
         for (int i = 0; i < NU; i++) begin
            if (wr_ctrl[i]) ctrl_r[i] <= pwdata[REG_W-1:0];
            if (f7_hit[i]) ctrl_r[i][CTRL_RUN] <= 1'b0;
         end
      end
   end

   // Configuration, sync/output and event enables
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NU; i++) begin
            conf_r[i] <= REG_RESET;
            soc_r[i]  <= REG_RESET;
            evt_r[i]  <= '0;
         end
      end else if (wr_go) begin
         for (int i = 0; i < NU; i++) begin
            if (int'(acc_unit) == i) begin
               if (acc_ofs == OFS_CONF) conf_r[i] <= pwdata[REG_W-1:0];
               if (acc_ofs == OFS_SOC)  soc_r[i]  <= pwdata[REG_W-1:0];
               if (acc_ofs == OFS_EVT)  evt_r[i]  <= pwdata[3:0] & EVT_WMASK;
            end
         end
      end
   end

   // Halt holds a slave stopped until its chain drops or software reruns it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         halt_r <= '0;
      end else begin
         for (int i = 0; i < NU; i++) begin
            if (f7_hit[i]) halt_r[i] <= 1'b1;
            else if (run_wr[i] || !run_eff[i]) halt_r[i] <= 1'b0;
         end
      end
   end

   // Running state, all units change on the same edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) unit_running <= '0;
      else          unit_running <= run_now;
   end

   // ------------------------------------------------------------
   // Clock source and prescaler
   // ------------------------------------------------------------
   // Divider cleared while a unit is stopped keeps chained units on one phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NU; i++) pre_cnt_r[i] <= '0;
         count_tick <= '0;
      end else begin
         for (int i = 0; i < NU; i++) begin
            logic src;
            logic [7:0] m;
            src = conf_r[i][CONF_CLKSEL] ? pll_tick : io_tick;
            m   = pre_mask(ctrl_r[i][CTRL_PRE+:2]);
            count_tick[i] <= 1'b0;
            if (!run_now[i]) begin
               pre_cnt_r[i] <= '0;
            end else if (src) begin
               pre_cnt_r[i]  <= (pre_cnt_r[i] & m) == m ? 8'h00 : pre_cnt_r[i] + 8'h01;
               count_tick[i] <= (pre_cnt_r[i] & m) == m;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Event sources
   // ------------------------------------------------------------
   logic [NU-1:0] in_act;
   logic [NU-1:0] in_evt;
   logic [NU-1:0] mis_now;
   logic [NU-1:0] sync_err;

   generate
      for (genvar i = 0; i < NU; i++) begin : g_evt
         localparam int P = (i + NU - 1) % NU;
         assign in_act[i]   = engine[i].ext_in ^ evt_r[i][EVT_IN_POL];
         // Edge and level inputs both fire once at the active start
         assign in_evt[i]   = in_act[i] & ~in_q_r[i];
         // A slave out of step with its predecessor
         assign mis_now[i]  = slave[i] & (unit_running[i] ^ unit_running[P]);
         assign sync_err[i] = mis_now[i] & ~mis_q_r[i];
         assign ec_req[i]   = evt_r[i][EVT_EN_EC] & engine[i].match_rb;
         assign capture_irq_req[i] = evt_r[i][EVT_EN_CAPTURE_IRQ]
                            & (in_evt[i] | engine[i].retrig | engine[i].capture | sync_err[i]);
      end
   endgenerate

   // Edge history for input and mismatch detection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_q_r  <= '0;
         mis_q_r <= '0;
      end else begin
         in_q_r  <= in_act;
         mis_q_r <= mis_now;
      end
   end

   // Per-unit request pulses
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         end_of_cycle_irq <= '0;
         capture_irq      <= '0;
      end else begin
         end_of_cycle_irq <= ec_req;
         capture_irq      <= capture_irq_req;
      end
   end

   // Vector request; unit 1 has no vector, lowest address wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vec_valid <= 1'b0;
         vec_addr  <= VEC_NONE;
      end else begin
         vec_valid <= capture_irq_req[UNIT_THIRD] | ec_req[UNIT_THIRD] | capture_irq_req[0] | ec_req[0];
         if (capture_irq_req[UNIT_THIRD])    vec_addr <= VEC_U2_CAPTURE_IRQ;
         else if (ec_req[UNIT_THIRD]) vec_addr <= VEC_U2_EC;
         else if (capture_irq_req[0])        vec_addr <= VEC_U0_CAPTURE_IRQ;
         else if (ec_req[0])          vec_addr <= VEC_U0_EC;
         else                         vec_addr <= VEC_NONE;
      end
   end

   // ------------------------------------------------------------
   // ADC strobe
   // ------------------------------------------------------------
   logic [NU-1:0] strobe_nxt;

   // Centred mode uses reset-A as a free marker; software keeps it nonzero
   always_comb begin
      strobe_nxt = '0;
      for (int i = 0; i < NU; i++) begin
         if (conf_r[i][CONF_MODE+:2] == MODE_CENTRED) begin
            unique case (soc_r[i][SOC_SYNC+:2])
               SYNC_A_LEAD:  strobe_nxt[i] = engine[i].match_ra & engine[i].count_down;
               SYNC_A_TRAIL: strobe_nxt[i] = engine[i].match_ra & ~engine[i].count_down;
               default:      strobe_nxt[i] = 1'b0;
            endcase
         end else begin
            unique case (soc_r[i][SOC_SYNC+:2])
               SYNC_A_LEAD:  strobe_nxt[i] = engine[i].match_sa;
               SYNC_A_TRAIL: strobe_nxt[i] = engine[i].match_ra | engine[i].fault_a;
               SYNC_B_LEAD:  strobe_nxt[i] = engine[i].match_sb;
               SYNC_B_TRAIL: strobe_nxt[i] = engine[i].match_rb | engine[i].fault_b;
            endcase
         end
      end
   end

   // One cycle per event, gated by the running state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) adc_strobe <= '0;
      else          adc_strobe <= strobe_nxt & unit_running;
   end

   // ------------------------------------------------------------
   // Pin routing
   // ------------------------------------------------------------
   // Disabled pins drop their enable and return to the port logic
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pins <= '0;
      end else begin
         for (int i = 0; i < NU; i++) begin
            pins[i].a_oe <= soc_r[i][SOC_A_EN];
            pins[i].a    <= soc_r[i][SOC_A_EN] & engine[i].gen_a;
            pins[i].b_oe <= soc_r[i][SOC_B_EN];
            pins[i].b    <= soc_r[i][SOC_B_EN] & engine[i].gen_b;
         end
      end
   end

   // Second pins of unit 2 pick their source through the selectors
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         unit2_third_output  <= 1'b0;
         unit2_third_oe      <= 1'b0;
         unit2_fourth_output <= 1'b0;
         unit2_fourth_oe     <= 1'b0;
      end else begin
         unit2_third_oe      <= soc_r[UNIT_THIRD][SOC_C_EN];
         unit2_third_output  <= soc_r[UNIT_THIRD][SOC_C_EN]
                              & (soc_r[UNIT_THIRD][SOC_S22] ? engine[UNIT_THIRD].gen_b
                                                            : engine[UNIT_THIRD].gen_a);
         unit2_fourth_oe     <= soc_r[UNIT_THIRD][SOC_D_EN];
         unit2_fourth_output <= soc_r[UNIT_THIRD][SOC_D_EN]
                              & (soc_r[UNIT_THIRD][SOC_S23] ? engine[UNIT_THIRD].gen_a
                                                            : engine[UNIT_THIRD].gen_b);
      end
   end

endmodule : pss_top

// ==== sim/pss_assertions.sv ====
// Port-level checks for the power stage sync and output block
`timescale 1ns/1ps
module pss_assertions (
   // Clock, reset and bus handshake
   input wire logic                       pclk,
   input wire logic                       presetn,
   input wire logic                       psel,
   input wire logic                       penable,
   input wire logic                       pready,
   // Clock ticks and engine status
   input wire logic                       io_tick,
   input wire logic                       pll_tick,
   input wire pss_pkg::pss_engine_t [2:0] engine,
   // Unit results
   input wire logic [2:0]                 count_tick,
   input wire logic [2:0]                 unit_running,
   input wire logic [2:0]                 adc_strobe,
   input wire logic [2:0]                 end_of_cycle_irq,
   input wire pss_pkg::pss_pins_t [2:0]   pins,
   input wire logic                       vec_valid,
   input wire logic [15:0]                vec_addr
);
   import pss_pkg::*;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Bus answers after exactly one wait state, as a single-cycle pulse
   property p_wait; psel && penable && !pready |=> pready; endproperty
   a_wait: assert property (p_wait) else $error("bus answer late");
   property p_pulse; pready |=> !pready; endproperty
   a_pulse: assert property (p_pulse) else $error("bus answer too long");
   // Cycle-end request needs its cause one cycle earlier; vector requests carry a known address
   property p_ec; end_of_cycle_irq[0] |-> $past(engine[0].match_rb); endproperty
   a_ec: assert property (p_ec) else $error("cycle end without match");
   property p_vec; vec_valid |-> vec_addr inside {16'h0001, 16'h0002, 16'h0005, 16'h0006};
   endproperty
   a_vec: assert property (p_vec) else $error("bad vector address");
   // Strobe is one cycle wide and only from a running unit
   property p_strobe; adc_strobe[0] |=> !adc_strobe[0]; endproperty
   a_strobe: assert property (p_strobe) else $error("strobe too wide");
   property p_strun; adc_strobe[0] |-> $past(unit_running[0]); endproperty
   a_strun: assert property (p_strun) else $error("strobe while stopped");
   property p_pin; pins[0].a == ($past(engine[0].gen_a) && pins[0].a_oe); endproperty
   a_pin: assert property (p_pin) else $error("pin A not following generator");
   property p_tick; count_tick[0] |-> $past(io_tick || pll_tick); endproperty
   a_tick: assert property (p_tick) else $error("count tick without source");
endmodule : pss_assertions

bind pss_top pss_assertions u_chk (.pclk, .presetn, .psel, .penable, .pready, .io_tick,
   .pll_tick, .engine, .count_tick, .unit_running, .adc_strobe, .end_of_cycle_irq, .pins,
   .vec_valid, .vec_addr);

// ==== sim/pss_adc_model.sv ====
// Sample-and-hold model that counts conversion triggers
`timescale 1ns/1ps
module pss_adc_model (
   // Clock and reset
   input wire logic       pclk,
   input wire logic       presetn,
   // Strobes in, conversions out
   input wire logic [2:0] adc_strobe,
   output logic     [7:0] conv_count
);
   // One conversion per strobe cycle; a wide strobe would double count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) conv_count <= 8'h00;
      else conv_count <= conv_count + 8'(|adc_strobe);
   end
endmodule : pss_adc_model

// ==== sim/test_pwm_stage_sync_clock_irq.sv ====
// Self-checking bench for the power stage sync and output block
`timescale 1ns/1ps
module test_pwm_stage_sync_clock_irq;
   import pss_pkg::*;
   logic             pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, io_tick = 0;
   logic [7:0]       paddr = 8'h00, conv;
   logic [31:0]      pwdata = 32'h0, prdata, rd;
   logic [2:0][12:0] engine = {13'h1000, 13'h0, 13'h1000};
   logic             pready, pslverr, se, vec_valid, unit2_third_output, unit2_third_oe;
   logic             unit2_fourth_output, unit2_fourth_oe;
   logic [2:0]       count_tick, unit_running, adc_strobe, end_of_cycle_irq, capture_irq;
   pss_pins_t [2:0]  pins;
   logic [15:0]      vec_addr;
   int               err_count = 0, checked = 0;
   // Free clock and a half-rate slow tick
   always #2.5 pclk = ~pclk;
   always @(posedge pclk) io_tick <= ~io_tick;
   pss_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF),
      .prdata, .pready, .pslverr, .io_tick, .pll_tick(1'b0), .engine, .count_tick,
      .unit_running, .adc_strobe, .end_of_cycle_irq, .capture_irq, .pins, .unit2_third_output,
      .unit2_third_oe, .unit2_fourth_output, .unit2_fourth_oe, .vec_valid, .vec_addr);
   pss_adc_model u_adc (.pclk, .presetn, .adc_strobe, .conv_count(conv));
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic final_report;
      $display("checks %0d errors %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : final_report
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         err_count++;
         $display("BAD %s exp %h seen %h", nm, e, s);
      end
   endtask : chk
   // One bus transfer; request held until the answer edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge pclk) penable <= 1'b1;
      do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin err_count++; final_report(); end
      rd = prdata;
      se = pslverr;
      {psel, penable} <= 2'b00;
   endtask : apb
   task automatic pulse(input int u, input logic [12:0] m);
      @(posedge pclk) engine[u] <= engine[u] | m;
      @(posedge pclk) engine[u] <= engine[u] & ~m;
      #1;
   endtask : pulse
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_regs;
      apb(0, 8'h08, 0);
      chk("soc0", rd, 0);
      apb(0, 8'h28, 0);
      chk("soc2", rd, 0);
      apb(0, 8'hC0, 0);
      chk("slverr", se, 1);
   endtask : t_regs
   // Generator A high, B low; both source selections
   task automatic t_pins;
      for (int i = 0; i < 2; i++) begin
         apb(1, 8'h28, i ? 32'hCF : 32'h0F);
         apb(0, 8'h28, 0);
         chk("soc2", rd, i ? 32'hCF : 32'h0F);
         chk("pins", {pins[2], unit2_third_output, unit2_third_oe, unit2_fourth_output,
            unit2_fourth_oe}, i ? 8'hD7 : 8'hDD);
      end
   endtask : t_pins
   // End-of-cycle and capture on units 0 and 2
   task automatic t_irq;
      for (int i = 0; i < 4; i++) begin
         apb(1, 8'(i / 2 * 32 + 12), 32'(i % 2 + 1));
         pulse(i / 2 * 2, (i % 2) ? ((i / 2) ? 13'h002 : 13'h004) : 13'h080);
         chk("irq", {capture_irq, end_of_cycle_irq}, 1 << (i % 2 * 3 + i / 2 * 2));
         for (int n = 0; n < 4 && vec_valid !== 1'b1; n++) @(posedge pclk) #1;
         chk("vec", vec_addr, 6 - i % 2 - i / 2 * 4);
      end
   endtask : t_irq
   // Two slaves behind a master, strobe, local and chained faults
   task automatic t_chain;
      apb(1, 8'h10, 4);
      apb(1, 8'h20, 4);
      apb(1, 8'h08, 32'h11);
      apb(1, 8'h1C, 4);
      apb(1, 8'h00, 1);
      #1;
      chk("start", unit_running, 0);
      @(posedge pclk) #1;
      chk("start", unit_running, 7);
      pulse(0, 13'h200);
      @(posedge pclk) #1;
      chk("adc", conv, 1);
      apb(1, 8'h04, 32'h18);
      pulse(0, 13'h210);
      pulse(0, 13'h200);
      @(posedge pclk) #1;
      chk("adc", conv, 2);
      pulse(1, 13'h040);
      chk("local", unit_running, 7);
      pulse(1, 13'h001);
      repeat (2) @(posedge pclk);
      #1;
      chk("halt", unit_running, 0);
   endtask : t_chain
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_pins();
      t_irq();
      t_chain();
      final_report();
   end
endmodule : test_pwm_stage_sync_clock_irq
